// file: design/fpsg_guard.sv
/*
  Flash page security guard: judges each flash read, write or erase by
  its source and target, keeps the write/erase enables, the key
  sequencer and the reset source flags.
  Assumes: the flash array presents the lock byte on lock_byte during
  reset; a reset controller turns flash_err_rst into srst; all inputs
  come from logic on clk.
*/
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps

// Behaviour
// - Firmware flash modification needs write enable set
// - Firmware page erase needs both enables set
// - Lock byte sits at last user flash byte
// - Inverted lock byte counts locked pages from zero
// - Lock byte page locked once any page locked
// - Unlocked pages open to every source
// - Locked pages: debug dropped, unlocked firmware resets
// - Lock page access follows locked-page policy when locked
// - Lock byte read follows the same policy
// - Unlocked: debug may erase lock page, firmware resets
// - Locked: only debug device erase clears lock
// - Lock byte write once set: debug dropped, firmware resets
// - Reserved area: debug dropped, firmware resets
// - Debug device erase wipes every page
// - Flash error resets device, flag survives reset
// - Prohibited debug requests dropped without reset
// - Written lock byte frozen until device erase
// - New lock byte takes effect after reset
// - Interrupts held pending during flash operation
// - Firmware write with both enables erases whole page
// - Key 0xa5,0xf1 per firmware modification, else locked
module fpsg_guard
  import fpsg_pkg::*;
#(
  parameter int             ADDR_W    = 17,
  parameter logic [16:0]    LOCK_ADDR = 17'h1fbff,
  parameter int             OP_CYCLES = 8
) (
  input  wire logic              clk,         // 40 MHz clock
  input  wire logic              srst,        // Device reset, sync, high
  input  wire logic              por,         // Reset is a power-on reset
  input  wire logic [7:0]        lock_byte,   // Lock byte from flash array
  input  wire logic [1:0]        reg_addr,    // Register offset
  input  wire logic [7:0]        reg_wdata,   // Register write data
  input  wire logic              reg_wr,      // Register write strobe
  input  wire logic              reg_rd,      // Register read strobe
  output logic      [7:0]        reg_rdata,   // Read data, cycle after rd
  input  wire logic              acc_valid,   // Access request
  output logic                   acc_ready,   // Guard can take request
  input  wire logic              acc_src,     // 1 debug port, 0 firmware
  input  wire logic [1:0]        acc_op,      // Operation code
  input  wire logic [ADDR_W-1:0] acc_addr,    // Target flash address
  input  wire logic [ADDR_W-1:0] exec_addr,   // Executing instruction address
  output logic                   rsp_valid,   // Verdict pulse
  output logic                   rsp_grant,   // Access performed
  output logic                   rsp_drop,    // Access ignored
  output logic                   flash_err_rst, // Device reset request pulse
  output logic                   cmd_valid,   // Command pulse to flash array
  output logic      [1:0]        cmd_op,      // Command operation
  output logic      [ADDR_W-1:0] cmd_addr,    // Command address
  output logic                   irq_hold     // Hold interrupts pending
);

  localparam int PW = ADDR_W - FPSG_PAGE_SHIFT;
  localparam logic [PW-1:0] LOCK_PAGE = PW'(LOCK_ADDR >> FPSG_PAGE_SHIFT);
  localparam logic [7:0]    OP_CNT    = 8'(OP_CYCLES);

  typedef struct packed {
    logic              wr_en;
    logic              er_en;
    fpsg_key_e         key;
    logic              ferr_flag;
    logic              por_flag;
    logic              ferr_pend;
    logic [7:0]        lock_val;
    logic              cap_pend;
    logic [7:0]        busy_cnt;
    logic [7:0]        rdata;
    logic              rsp_valid;
    logic              rsp_grant;
    logic              rsp_drop;
    logic              err_rst;
    logic              cmd_valid;
    logic [1:0]        cmd_op;
    logic [ADDR_W-1:0] cmd_addr;
  } fpsg_state_s;

  fpsg_state_s   s;
  fpsg_state_s   next_s;
  logic [PW-1:0] locked_n;
  logic          any_locked;
  logic [PW-1:0] tgt_page;
  logic [PW-1:0] exec_page;
  logic          tgt_locked;
  logic          exec_locked;
  logic          is_dbg;
  logic          acc_fire;
  logic [1:0]    eff_op;
  logic          is_mod;
  fpsg_verdict_e verdict;

  // Captured count only; a later lock byte write cannot move it
  assign locked_n   = PW'(~s.lock_val);
  assign any_locked = s.lock_val != FPSG_LOCK_BLANK;
  assign tgt_page   = acc_addr[ADDR_W-1:FPSG_PAGE_SHIFT];
  assign exec_page  = exec_addr[ADDR_W-1:FPSG_PAGE_SHIFT];
  assign tgt_locked  = (tgt_page < locked_n) ||
                       (tgt_page == LOCK_PAGE && any_locked);
  assign exec_locked = (exec_page < locked_n) ||
                       (exec_page == LOCK_PAGE && any_locked);
  assign is_dbg   = acc_src == FPSG_SRC_DEBUG;
  assign acc_ready = !srst && !s.cap_pend && (s.busy_cnt == FPSG_BUSY_RST);
  assign acc_fire  = acc_valid && acc_ready;

  // A firmware write with both enables is a page erase
  always_comb begin
    eff_op = acc_op;
    if (!is_dbg && acc_op == FPSG_OP_WRITE && s.er_en) begin
      eff_op = FPSG_OP_PAGE_ERA;
    end
  end

  assign is_mod = eff_op != FPSG_OP_READ;

  always_comb begin
    if (eff_op == FPSG_OP_DEV_ERA) begin
      verdict = is_dbg ? FPSG_V_GRANT : FPSG_V_DROP;
    end else if (acc_addr > ADDR_W'(LOCK_ADDR)) begin
      verdict = is_dbg ? FPSG_V_DROP : FPSG_V_FERR;
    end else if (eff_op == FPSG_OP_PAGE_ERA && tgt_page == LOCK_PAGE) begin
      if (!is_dbg) begin
        verdict = FPSG_V_FERR;
      end else begin
        verdict = any_locked ? FPSG_V_DROP : FPSG_V_GRANT;
      end
    end else if (eff_op == FPSG_OP_WRITE && acc_addr == ADDR_W'(LOCK_ADDR) &&
                 s.lock_val != FPSG_LOCK_BLANK) begin
      verdict = is_dbg ? FPSG_V_DROP : FPSG_V_FERR;
    end else if (tgt_locked) begin
      if (is_dbg) begin
        verdict = FPSG_V_DROP;
      end else begin
        verdict = exec_locked ? FPSG_V_GRANT : FPSG_V_FERR;
      end
    end else begin
      verdict = FPSG_V_GRANT;
    end
  end

  always_comb begin
    next_s           = s;
    next_s.rsp_valid = 1'b0;
    next_s.rsp_grant = 1'b0;
    next_s.rsp_drop  = 1'b0;
    next_s.err_rst   = 1'b0;
    next_s.cmd_valid = 1'b0;

    if (s.busy_cnt != FPSG_BUSY_RST) begin
      next_s.busy_cnt = s.busy_cnt - 8'h01;
    end
    // Lock byte sampled once after reset, so new values wait for the next
    if (s.cap_pend) begin
      next_s.lock_val = lock_byte;
      next_s.cap_pend = 1'b0;
    end

    if (reg_wr) begin
      unique case (reg_addr)
        FPSG_REG_CTRL: begin
          next_s.wr_en = reg_wdata[FPSG_CTRL_WE_BIT];
          next_s.er_en = reg_wdata[FPSG_CTRL_EE_BIT];
        end
        FPSG_REG_KEY: begin
          unique case (s.key)
            FPSG_KEY_IDLE: begin
              next_s.key = (reg_wdata == FPSG_KEY_FIRST) ?
                           FPSG_KEY_HALF : FPSG_KEY_LOCKED;
            end
            FPSG_KEY_HALF: begin
              next_s.key = (reg_wdata == FPSG_KEY_SECOND) ?
                           FPSG_KEY_ARMED : FPSG_KEY_LOCKED;
            end
            FPSG_KEY_ARMED: begin
              next_s.key = FPSG_KEY_LOCKED;
            end
            FPSG_KEY_LOCKED: begin
              next_s.key = FPSG_KEY_LOCKED;
            end
            default: begin
              next_s.key = FPSG_KEY_LOCKED;
            end
          endcase
        end
        // Flags are hardware owned; software writes change nothing
        default: begin
        end
      endcase
    end

    if (reg_rd) begin
      unique case (reg_addr)
        FPSG_REG_CTRL: begin
          next_s.rdata = {6'h00, s.er_en, s.wr_en};
        end
        FPSG_REG_KEY: begin
          next_s.rdata = {(s.busy_cnt != FPSG_BUSY_RST), 3'h0, s.key};
        end
        FPSG_REG_RST_SRC: begin
          next_s.rdata = {6'h00, s.ferr_flag, s.por_flag};
        end
        FPSG_REG_STATUS: begin
          next_s.rdata = ~s.lock_val;
        end
        default: begin
          next_s.rdata = FPSG_RDATA_RST;
        end
      endcase
    end

    if (acc_fire) begin
      next_s.rsp_valid = 1'b1;
      if (!is_dbg && is_mod && !s.wr_en) begin
        next_s.rsp_drop = 1'b1;
      end else if (!is_dbg && eff_op == FPSG_OP_PAGE_ERA && !s.er_en) begin
        // A firmware erase needs the erase enable beside the write enable
        next_s.rsp_drop = 1'b1;
      end else if (verdict == FPSG_V_FERR) begin
        next_s.err_rst   = 1'b1;
        next_s.ferr_pend = 1'b1;
      end else if (verdict == FPSG_V_DROP) begin
        next_s.rsp_drop = 1'b1;
      end else if (!is_dbg && is_mod && s.key != FPSG_KEY_ARMED) begin
        // Unkeyed attempt closes flash modification until reset
        next_s.rsp_drop = 1'b1;
        next_s.key      = FPSG_KEY_LOCKED;
      end else begin
        next_s.rsp_grant = 1'b1;
        next_s.cmd_valid = 1'b1;
        next_s.cmd_op    = eff_op;
        next_s.cmd_addr  = acc_addr;
        if (is_mod) begin
          next_s.busy_cnt = OP_CNT;
          if (!is_dbg) begin
            next_s.key = FPSG_KEY_IDLE;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s           <= '0;
      s.key       <= FPSG_KEY_IDLE;
      s.lock_val  <= FPSG_LOCK_BLANK;
      s.cap_pend  <= 1'b1;
      // Kept over a long reset; power loss wipes the record
      s.ferr_flag <= !por && (s.ferr_pend || (s.cap_pend && s.ferr_flag));
      s.por_flag  <= por;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata     = s.rdata;
  assign rsp_valid     = s.rsp_valid;
  assign rsp_grant     = s.rsp_grant;
  assign rsp_drop      = s.rsp_drop;
  assign flash_err_rst = s.err_rst;
  assign cmd_valid     = s.cmd_valid;
  assign cmd_op        = s.cmd_op;
  assign cmd_addr      = s.cmd_addr;
  // Interrupts stay pending while the array is busy
  assign irq_hold      = s.busy_cnt != FPSG_BUSY_RST;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_WE_NEEDED: assert property (
    acc_fire && !is_dbg && acc_op == FPSG_OP_WRITE && !s.wr_en
    |=> rsp_drop && !rsp_grant && !flash_err_rst)
    else $error("firmware write passed without write enable");

  AST_ERASE_BOTH: assert property (
    acc_fire && !is_dbg && acc_op == FPSG_OP_WRITE && s.wr_en && s.er_en
    |=> !cmd_valid || cmd_op == FPSG_OP_PAGE_ERA)
    else $error("write with both enables was not a page erase");

  AST_DBG_NO_RESET: assert property (
    acc_fire && is_dbg |=> !flash_err_rst)
    else $error("debug request caused a flash error reset");

  AST_RESERVED_FW: assert property (
    acc_fire && !is_dbg && acc_op == FPSG_OP_READ &&
    acc_addr > ADDR_W'(LOCK_ADDR) |=> flash_err_rst && !rsp_grant)
    else $error("firmware reserved access did not reset");

  AST_DEV_ERASE: assert property (
    acc_fire && is_dbg && acc_op == FPSG_OP_DEV_ERA
    |=> cmd_valid && cmd_op == FPSG_OP_DEV_ERA)
    else $error("debug device erase not issued");

  AST_KEY_STICKY: assert property (
    s.key == FPSG_KEY_LOCKED |=> s.key == FPSG_KEY_LOCKED)
    else $error("locked key sequencer reopened before reset");

  AST_LOCK_STABLE: assert property (
    !s.cap_pend |=> $stable(s.lock_val))
    else $error("lock byte changed without a reset");

  AST_IRQ_HOLD: assert property (
    s.cmd_valid && s.cmd_op != FPSG_OP_READ |-> irq_hold && s.busy_cnt == OP_CNT)
    else $error("interrupts not held during flash operation");

  AST_LOCKPAGE_FW_ERASE: assert property (
    acc_fire && !is_dbg && s.wr_en && s.er_en && acc_op == FPSG_OP_WRITE &&
    tgt_page == LOCK_PAGE |=> flash_err_rst)
    else $error("firmware erase of lock page did not reset");

  AST_DBG_LOCKED_READ: assert property (
    acc_fire && is_dbg && acc_op == FPSG_OP_READ && tgt_locked
    |=> rsp_drop && !rsp_grant && !flash_err_rst)
    else $error("debug read of locked page granted");

  AST_FERR_FLAG: assert property (
    @(posedge clk) disable iff (1'b0) srst && !por && s.ferr_pend |=> s.ferr_flag)
    else $error("flash error flag lost across reset");

  COV_FW_ERR: cover property (acc_fire && !is_dbg ##1 flash_err_rst);
  COV_DBG_DROP: cover property (acc_fire && is_dbg ##1 rsp_drop);
  COV_KEYED_WRITE: cover property (s.key == FPSG_KEY_ARMED ##[1:8] cmd_valid);
  COV_LOCK_CAPTURED: cover property (s.cap_pend ##1 any_locked);
  COV_DBG_DEV_ERASE: cover property (acc_fire && is_dbg && acc_op == FPSG_OP_DEV_ERA);

  AST_FW_ERASE_EE: assert property (
    acc_fire && !is_dbg && acc_op == FPSG_OP_PAGE_ERA && !s.er_en
    |=> rsp_drop && !cmd_valid)
    else $error("firmware page erase ran without erase enable");

  AST_BUSY_STEP: assert property (
    s.busy_cnt != FPSG_BUSY_RST |=> s.busy_cnt == $past(s.busy_cnt) - 8'h01)
    else $error("busy counter did not count down");

  AST_BUSY_NO_TAKE: assert property (
    irq_hold |-> !acc_ready)
    else $error("request taken while flash array busy");

  AST_LOCK_FROZEN: assert property (
    acc_fire && acc_op == FPSG_OP_WRITE && acc_addr == ADDR_W'(LOCK_ADDR) &&
    s.lock_val != FPSG_LOCK_BLANK |=> !cmd_valid)
    else $error("written lock byte changed again");

  AST_DBG_LOCK_ERASE: assert property (
    acc_fire && is_dbg && acc_op == FPSG_OP_PAGE_ERA && tgt_page == LOCK_PAGE &&
    any_locked |=> rsp_drop && !cmd_valid)
    else $error("debug page erase cleared a locked lock page");

  AST_ONE_VERDICT: assert property (
    rsp_valid || rsp_grant || rsp_drop || flash_err_rst
    |-> rsp_valid && $onehot({rsp_grant, rsp_drop, flash_err_rst}))
    else $error("access verdict not exactly one outcome");

  AST_LOCK_CAPTURE: assert property (
    !srst && s.cap_pend |=> s.lock_val == $past(lock_byte))
    else $error("lock byte not captured after reset");

  AST_LOCKED_FW_RESET: assert property (
    acc_fire && !is_dbg && acc_op == FPSG_OP_READ && tgt_locked && !exec_locked
    |=> flash_err_rst && !rsp_grant)
    else $error("unlocked firmware read of locked page did not reset");

endmodule

// file: design/fpsg_pkg.sv
/*
  Constants and enumerations for the flash page security guard.
  Assumes 512-byte flash pages and an 8-bit software register port.
*/
package fpsg_pkg;

  // Flash page geometry
  localparam int FPSG_PAGE_SHIFT = 9;

  // Key sequence that arms one flash modification
  localparam logic [7:0] FPSG_KEY_FIRST  = 8'ha5;
  localparam logic [7:0] FPSG_KEY_SECOND = 8'hf1;

  // Lock byte value meaning nothing locked and never written
  localparam logic [7:0] FPSG_LOCK_BLANK = 8'hff;

  // Register offsets on the software port
  localparam logic [1:0] FPSG_REG_CTRL    = 2'h0;
  localparam logic [1:0] FPSG_REG_KEY     = 2'h1;
  localparam logic [1:0] FPSG_REG_RST_SRC = 2'h2;
  localparam logic [1:0] FPSG_REG_STATUS  = 2'h3;

  // Field positions
  localparam int FPSG_CTRL_WE_BIT  = 0;
  localparam int FPSG_CTRL_EE_BIT  = 1;
  localparam int FPSG_RST_POR_BIT  = 0;
  localparam int FPSG_RST_FERR_BIT = 1;
  localparam int FPSG_KEY_BUSY_BIT = 7;

  // Reset values
  localparam logic [7:0] FPSG_RDATA_RST = 8'h00;
  localparam logic [7:0] FPSG_BUSY_RST  = 8'h00;

  // Key sequencer, one-hot
  typedef enum logic [3:0] {
    FPSG_KEY_IDLE   = 4'b0001,
    FPSG_KEY_HALF   = 4'b0010,
    FPSG_KEY_ARMED  = 4'b0100,
    FPSG_KEY_LOCKED = 4'b1000
  } fpsg_key_e;

  // Access source
  typedef enum logic {
    FPSG_SRC_FW    = 1'b0,
    FPSG_SRC_DEBUG = 1'b1
  } fpsg_src_e;

  // Access operation
  typedef enum logic [1:0] {
    FPSG_OP_READ      = 2'h0,
    FPSG_OP_WRITE     = 2'h1,
    FPSG_OP_PAGE_ERA  = 2'h2,
    FPSG_OP_DEV_ERA   = 2'h3
  } fpsg_op_e;

  // Verdict on one access
  typedef enum logic [1:0] {
    FPSG_V_GRANT = 2'h0,
    FPSG_V_DROP  = 2'h1,
    FPSG_V_FERR  = 2'h2
  } fpsg_verdict_e;

endpackage

// file: tb/fpsg_flash_model.sv
/*
  Flash array stand-in for the page security guard: keeps the lock byte
  that the guard captures after reset. Assumes the bench programs the
  lock byte as an external programmer would; writes carry no data here.
*/
`timescale 1ns/1ps
module fpsg_flash_model
  import fpsg_pkg::*;
(
  input  wire logic       clk,       // System clock
  input  wire logic       load,      // Program the lock byte
  input  wire logic [7:0] load_val,  // Value to program
  input  wire logic       cmd_valid, // Command pulse from guard
  input  wire logic [1:0] cmd_op,    // Command operation
  output logic      [7:0] lock_byte  // Lock byte seen by guard
);
  initial lock_byte = FPSG_LOCK_BLANK;
  // Device erase wipes every page, the lock byte page included
  always @(posedge clk) begin
    if (load) begin
      lock_byte <= load_val;
    end else if (cmd_valid && cmd_op == FPSG_OP_DEV_ERA) begin
      lock_byte <= FPSG_LOCK_BLANK;
    end
  end
endmodule

// file: tb/test_flash_page_security_guard.sv
/*
  Self-checking bench for the flash page security guard.
  Assumes the bench plays CPU, debug port and reset controller.
*/
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin samples_checked++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module test_flash_page_security_guard
  import fpsg_pkg::*;
;
  localparam logic [16:0] LA  = 17'h1fbff;
  localparam logic [16:0] LP  = 17'h1fa00;
  localparam logic [16:0] RSV = 17'h1fc00;
  localparam logic [16:0] P0  = 17'h00000;
  localparam logic [16:0] P1  = 17'h00200;
  localparam logic [16:0] P5  = 17'h00a00;
  localparam logic        FW  = FPSG_SRC_FW;
  localparam logic        DB  = FPSG_SRC_DEBUG;
  logic        clk, srst, por, reg_wr, reg_rd, acc_valid, acc_src, load;
  logic [1:0]  reg_addr, acc_op, cmd_op;
  logic [7:0]  reg_wdata, reg_rdata, lock_byte, load_val;
  logic [16:0] acc_addr, exec_addr, cmd_addr;
  logic        acc_ready, rsp_valid, rsp_grant, rsp_drop, flash_err_rst;
  logic        cmd_valid, irq_hold;
  int          err_total, samples_checked;

  fpsg_guard #(.OP_CYCLES(2)) dut (.clk(clk), .srst(srst), .por(por),
    .lock_byte(lock_byte), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_src(acc_src),
    .acc_op(acc_op), .acc_addr(acc_addr), .exec_addr(exec_addr),
    .rsp_valid(rsp_valid), .rsp_grant(rsp_grant), .rsp_drop(rsp_drop),
    .flash_err_rst(flash_err_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .irq_hold(irq_hold));
  fpsg_flash_model flash (.clk(clk), .load(load), .load_val(load_val),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .lock_byte(lock_byte));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic rst(input logic p);
    @(posedge clk);
    srst <= 1'b1;
    por <= p;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    por <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, e)
  endtask

  task automatic key;
    wr(FPSG_REG_KEY, FPSG_KEY_FIRST);
    wr(FPSG_REG_KEY, FPSG_KEY_SECOND);
  endtask

  // Verdict v: 0 grant, 1 drop, 2 flash-error reset
  task automatic acc(input logic s, input logic [1:0] op, input logic [16:0] a,
                     input logic [16:0] x, input int v, input logic [1:0] co);
    int n;
    n = 0;
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_src <= s;
    acc_op <= op;
    acc_addr <= a;
    exec_addr <= x;
    @(negedge clk);
    while (acc_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    acc_valid <= 1'b0;
    @(negedge clk);
    `CHK({rsp_valid, rsp_grant, rsp_drop, flash_err_rst}, {1'b1, v == 0, v == 1, v == 2})
    `CHK(cmd_valid, v == 0)
    if (v == 0) `CHK(cmd_op, co)
    if (v == 0) `CHK(cmd_addr, a)
    if (v == 0 && op != FPSG_OP_READ) `CHK({irq_hold, acc_ready}, 2'b10)
    // Verdict and command are one-cycle pulses
    @(negedge clk);
    `CHK({rsp_valid, flash_err_rst, cmd_valid}, 3'b000)
    repeat (4) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  initial begin
    {srst, por} = 2'b11;
    {reg_wr, reg_rd, acc_valid, acc_src, load} = '0;
    {reg_addr, acc_op, reg_wdata, load_val} = '0;
    {acc_addr, exec_addr} = '0;
    err_total = 0;
    samples_checked = 0;
    rst(1'b1);
    rd(FPSG_REG_CTRL, 8'h00);
    rd(FPSG_REG_KEY, 8'h01);
    rd(FPSG_REG_RST_SRC, 8'h01);
    rd(FPSG_REG_STATUS, 8'h00);
    wr(FPSG_REG_CTRL, 8'hfd);
    rd(FPSG_REG_CTRL, 8'h01);
    // Modify attempt without the key locks the sequencer
    acc(FW, FPSG_OP_WRITE, P5, P5, 1, 0);
    rd(FPSG_REG_KEY, 8'h08);
    rst(1'b1);
    key();
    acc(FW, FPSG_OP_WRITE, P5, P5, 1, 0);
    rd(FPSG_REG_KEY, 8'h04);
    wr(FPSG_REG_CTRL, 8'h01);
    acc(FW, FPSG_OP_WRITE, P5, P5, 0, FPSG_OP_WRITE);
    wr(FPSG_REG_CTRL, 8'h00);
    rd(FPSG_REG_KEY, 8'h01);
    key();
    wr(FPSG_REG_CTRL, 8'h03);
    acc(FW, FPSG_OP_WRITE, P5 + 17'h3, P5, 0, FPSG_OP_PAGE_ERA);
    wr(FPSG_REG_CTRL, 8'h02);
    key();
    acc(FW, FPSG_OP_WRITE, P5, P5, 1, 0);
    wr(FPSG_REG_CTRL, 8'h01);
    acc(FW, FPSG_OP_PAGE_ERA, P5, P5, 1, 0);
    acc(FW, FPSG_OP_WRITE, LA, P5, 0, FPSG_OP_WRITE);
    rd(FPSG_REG_STATUS, 8'h00);
    acc(DB, FPSG_OP_PAGE_ERA, LP, P0, 0, FPSG_OP_PAGE_ERA);
    acc(DB, FPSG_OP_READ, LA, P0, 0, FPSG_OP_READ);
    key();
    wr(FPSG_REG_CTRL, 8'h03);
    acc(FW, FPSG_OP_WRITE, LP, P5, 2, 0);
    rst(1'b0);
    rd(FPSG_REG_RST_SRC, 8'h02);
    // Direct write with the power flag set leaves the read-only flags alone
    wr(FPSG_REG_RST_SRC, 8'h01);
    rd(FPSG_REG_RST_SRC, 8'h02);
    wr(FPSG_REG_KEY, FPSG_KEY_FIRST);
    wr(FPSG_REG_KEY, 8'h00);
    rd(FPSG_REG_KEY, 8'h08);
    wr(FPSG_REG_CTRL, 8'h01);
    acc(FW, FPSG_OP_WRITE, P5, P5, 1, 0);
    // Two pages locked until the device erase; lock byte page with them
    @(posedge clk);
    load <= 1'b1;
    load_val <= 8'hfd;
    @(posedge clk);
    load <= 1'b0;
    rst(1'b1);
    rd(FPSG_REG_STATUS, 8'h02);
    acc(DB, FPSG_OP_READ, P1, P0, 1, 0);
    acc(DB, FPSG_OP_READ, P5, P0, 0, FPSG_OP_READ);
    acc(FW, FPSG_OP_READ, P1 + 17'h4, P0, 0, FPSG_OP_READ);
    acc(DB, FPSG_OP_WRITE, LP, P0, 1, 0);
    acc(FW, FPSG_OP_READ, LP, P1, 0, FPSG_OP_READ);
    acc(DB, FPSG_OP_READ, LA, P0, 1, 0);
    acc(FW, FPSG_OP_READ, LA, P1, 0, FPSG_OP_READ);
    acc(DB, FPSG_OP_PAGE_ERA, LP, P0, 1, 0);
    acc(DB, FPSG_OP_WRITE, LA, P0, 1, 0);
    acc(DB, FPSG_OP_READ, RSV, P0, 1, 0);
    key();
    wr(FPSG_REG_CTRL, 8'h01);
    acc(FW, FPSG_OP_WRITE, LA, P0, 2, 0);
    rst(1'b0);
    rd(FPSG_REG_RST_SRC, 8'h02);
    acc(FW, FPSG_OP_READ, P0, P5, 2, 0);
    rst(1'b1);
    acc(FW, FPSG_OP_READ, RSV, P0, 2, 0);
    rst(1'b1);
    acc(DB, FPSG_OP_DEV_ERA, P0, P0, 0, FPSG_OP_DEV_ERA);
    rst(1'b1);
    rd(FPSG_REG_STATUS, 8'h00);
    end_of_test();
  end
endmodule
